// ---- shared/tof_params.svh ----
// constants of the thermal overload status logic
`ifndef TOF_PARAMS_SVH
`define TOF_PARAMS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define TOF_CLK_MHZ      100
`define TOF_CYCLE_US     5000
`define TOF_DIV_W        20

// ----------------------------------------
// register offsets
// ----------------------------------------
`define TOF_OFS_CTRL     8'h00
`define TOF_OFS_ALM1     8'h04
`define TOF_OFS_ALM2     8'h08
`define TOF_OFS_INH      8'h0C
`define TOF_OFS_TRIPL    8'h10
`define TOF_OFS_DLY      8'h14
`define TOF_OFS_PICK     8'h18
`define TOF_OFS_SF       8'h1C
`define TOF_OFS_KMAX     8'h20
`define TOF_OFS_KMIN     8'h24
`define TOF_OFS_TEMPS    8'h28
`define TOF_OFS_NOMC     8'h2C
`define TOF_OFS_STAT     8'h30
`define TOF_OFS_IMAX     8'h34
`define TOF_OFS_CNTA     8'h38
`define TOF_OFS_CNTB     8'h3C
`define TOF_OFS_CNTC     8'h40
`define TOF_OFS_USED     8'h44

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define TOF_CTRL_CLR     8
`define TOF_RST_ALM1     12'h190
`define TOF_RST_ALM2     12'h190
`define TOF_RST_INH      12'h320
`define TOF_RST_TRIPL    12'h3E8
`define TOF_RST_PICK     16'h03E8
`define TOF_RST_TMIN     8'h00
`define TOF_RST_TMAX     8'h2D
`define TOF_FACTOR_ONE   9'h064
`define TOF_FACTOR_MAX   9'h1F4
`define TOF_I_LIGHT      16'h000A
`define TOF_I_HIGH       16'h07D0
`define TOF_NCNT         5
`define TOF_CW           16
`define TOF_CNT_MAX      16'hFFFF

`endif

// ---- shared/tof_pkg.sv ----
// types of the thermal overload status logic
package tof_pkg;
  typedef enum logic [1:0] {TOF_IDLE, TOF_TIMING, TOF_TRIPPED, TOF_BLOCKED} tof_fsm_t;
  typedef enum logic [2:0] {
    COND_NORMAL, COND_ALARM1, COND_ALARM2, COND_INHIBIT, COND_TRIP, COND_BLOCKED
  } tof_cond_t;
  typedef enum logic [1:0] {TH_LIGHT, TH_NORMAL, TH_OVERLOAD, TH_HIGH} tof_therm_t;
endpackage

// ---- shared/tof_cnt_if.sv ----
// activation counter bank connection
`timescale 1ns/1ps
`include "tof_params.svh"
interface tof_cnt_if;
  logic [`TOF_NCNT-1:0] inc;
  logic                 clr;
  logic [`TOF_CW-1:0]   cnt [`TOF_NCNT];
  modport owner (output inc, output clr, input cnt);
  modport bank  (input inc, input clr, output cnt);
endinterface

// ---- src/tof_cnt_bank.sv ----
// saturating activation counters
`timescale 1ns/1ps
`include "tof_params.svh"
module tof_cnt_bank (
  input logic       clk,
  input logic       rstn,
  tof_cnt_if.bank   cb
);
  genvar g;
  for (g = 0; g < `TOF_NCNT; g++) begin : g_cnt
    logic [`TOF_CW-1:0] c_reg;
    logic [`TOF_CW-1:0] c_next;
    // an increment in the clear cycle is kept
    always_comb begin
      if (cb.clr) begin
        c_next = cb.inc[g] ? `TOF_CW'(1) : '0;
      end else if (cb.inc[g] && c_reg != `TOF_CNT_MAX) begin
        c_next = c_reg + `TOF_CW'(1);
      end else begin
        c_next = c_reg;
      end
    end
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        c_reg <= '0;
      end else begin
        c_reg <= c_next;
      end
    end
    assign cb.cnt[g] = c_reg;
    a_cnt_saturate: assert property (@(posedge clk) disable iff (!rstn)
      c_reg == `TOF_CNT_MAX && !cb.clr |=> c_reg == `TOF_CNT_MAX)
      else $error("counter wrapped past maximum");
  end
endmodule

// ---- src/tof_status.sv ----
// thermal overload status, blocking and counting logic
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "tof_params.svh"
module tof_status #(
  parameter int unsigned CYCLE_CLKS = `TOF_CYCLE_US * `TOF_CLK_MHZ
) (
  input  logic                CLK,
  input  logic                RSTN,
  input  logic                PSEL,
  input  logic                PENABLE,
  input  logic                PWRITE,
  input  logic [7:0]          PADDR,
  input  logic [31:0]         PWDATA,
  output logic [31:0]         PRDATA,
  output logic                PREADY,
  output logic                PSLVERR,
  input  logic                BLOCK_IN,
  input  logic [15:0]         PHASE_A_CURRENT,
  input  logic [15:0]         PHASE_B_CURRENT,
  input  logic [15:0]         PHASE_C_CURRENT,
  input  logic [11:0]         THETA,
  input  logic [11:0]         THETA_EST,
  output logic                START,
  output logic                BLOCKED,
  output logic                ALARM1,
  output logic                ALARM2,
  output logic                INHIBIT,
  output logic                TRIP,
  output logic                TRIP_EXPECTED,
  output tof_pkg::tof_cond_t  CONDITION,
  output tof_pkg::tof_therm_t THERM_STATE,
  output logic                SF_FAULT,
  output logic                AMB_FAULT,
  output logic                NOMC_FAULT,
  output logic                AMBK_INCONS
);
  import tof_pkg::*;

  // ----------------------------------------
  // processing cycle divider
  // ----------------------------------------
  logic [`TOF_DIV_W-1:0] div_reg, div_next;
  logic                  cyc_en_reg, cyc_en_next;
  logic                  eval_reg;

  always_comb begin
    cyc_en_next = (div_reg == `TOF_DIV_W'(CYCLE_CLKS - 1));
    div_next    = cyc_en_next ? '0 : div_reg + `TOF_DIV_W'(1);
  end
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      div_reg    <= '0;
      cyc_en_reg <= 1'b0;
      eval_reg   <= 1'b0;
    end else begin
      div_reg    <= div_next;
      cyc_en_reg <= cyc_en_next;
      eval_reg   <= cyc_en_reg;
    end
  end

  // ----------------------------------------
  // blocking synchroniser and cycle samples
  // ----------------------------------------
  logic        blk_m1_reg, blk_m2_reg, blk_m3_reg, blk_lvl_reg, blk_lvl_next;
  logic        blk_s_reg, blk_s_next;
  logic [11:0] theta_reg, theta_next, est_reg, est_next;
  logic [15:0] imax_reg, imax_next, ab_max;

  always_comb begin
    blk_lvl_next = (blk_m2_reg == blk_m3_reg) ? blk_m3_reg : blk_lvl_reg;
    ab_max       = (PHASE_A_CURRENT > PHASE_B_CURRENT) ? PHASE_A_CURRENT : PHASE_B_CURRENT;
    blk_s_next   = blk_s_reg;
    theta_next   = theta_reg;
    est_next     = est_reg;
    imax_next    = imax_reg;
    if (cyc_en_reg) begin
      blk_s_next = blk_lvl_reg;
      theta_next = THETA;
      est_next   = THETA_EST;
      imax_next  = (ab_max > PHASE_C_CURRENT) ? ab_max : PHASE_C_CURRENT;
    end
  end
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      blk_m1_reg  <= 1'b0;
      blk_m2_reg  <= 1'b0;
      blk_m3_reg  <= 1'b0;
      blk_lvl_reg <= 1'b0;
      blk_s_reg   <= 1'b0;
      theta_reg   <= '0;
      est_reg     <= '0;
      imax_reg    <= '0;
    end else begin
      blk_m1_reg  <= BLOCK_IN;
      blk_m2_reg  <= blk_m1_reg;
      blk_m3_reg  <= blk_m2_reg;
      blk_lvl_reg <= blk_lvl_next;
      blk_s_reg   <= blk_s_next;
      theta_reg   <= theta_next;
      est_reg     <= est_next;
      imax_reg    <= imax_next;
    end
  end

  // ----------------------------------------
  // settings over apb
  // ----------------------------------------
  logic [3:0]  en_reg, en_next;
  logic        clr_reg, clr_next;
  logic [11:0] alm1_reg, alm1_next, alm2_reg, alm2_next;
  logic [11:0] inh_reg, inh_next, tripl_reg, tripl_next;
  logic [19:0] dly_reg, dly_next;
  logic [15:0] pick_reg, pick_next;
  logic [8:0]  sf_reg, sf_next, kmax_reg, kmax_next, kmin_reg, kmin_next;
  logic [8:0]  nomc_reg, nomc_next;
  logic [7:0]  tmin_reg, tmin_next, tmax_reg, tmax_next;
  logic        pready_reg, pready_next, perr_reg, perr_next;
  logic [31:0] prdata_reg, prdata_next, rd_val;
  logic        rd_hit, wr_go;
  logic [8:0]  sf_used_reg, k_used_reg, nomc_used_reg;
  logic        trip_exp_reg, sf_f_reg, amb_f_reg, nomc_f_reg, incons_reg;
  tof_cond_t   cond_reg;
  tof_therm_t  therm_reg;
  tof_cnt_if   cb ();

  always_comb begin
    rd_hit = 1'b1;
    unique case (PADDR)
      `TOF_OFS_CTRL:  rd_val = {28'h0000000, en_reg};
      `TOF_OFS_ALM1:  rd_val = {20'h00000, alm1_reg};
      `TOF_OFS_ALM2:  rd_val = {20'h00000, alm2_reg};
      `TOF_OFS_INH:   rd_val = {20'h00000, inh_reg};
      `TOF_OFS_TRIPL: rd_val = {20'h00000, tripl_reg};
      `TOF_OFS_DLY:   rd_val = {12'h000, dly_reg};
      `TOF_OFS_PICK:  rd_val = {16'h0000, pick_reg};
      `TOF_OFS_SF:    rd_val = {23'h000000, sf_reg};
      `TOF_OFS_KMAX:  rd_val = {23'h000000, kmax_reg};
      `TOF_OFS_KMIN:  rd_val = {23'h000000, kmin_reg};
      `TOF_OFS_TEMPS: rd_val = {16'h0000, tmax_reg, tmin_reg};
      `TOF_OFS_NOMC:  rd_val = {23'h000000, nomc_reg};
      `TOF_OFS_STAT:  rd_val = {19'h00000, trip_exp_reg, incons_reg, nomc_f_reg,
                                amb_f_reg, sf_f_reg, 2'h0, therm_reg, 1'b0, cond_reg};
      `TOF_OFS_IMAX:  rd_val = {16'h0000, imax_reg};
      `TOF_OFS_CNTA:  rd_val = {cb.cnt[1], cb.cnt[0]};
      `TOF_OFS_CNTB:  rd_val = {cb.cnt[3], cb.cnt[2]};
      `TOF_OFS_CNTC:  rd_val = {16'h0000, cb.cnt[4]};
      `TOF_OFS_USED:  rd_val = {5'h00, nomc_used_reg, k_used_reg, sf_used_reg};
      default: begin
        rd_val = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    wr_go       = PSEL && PENABLE && pready_reg && PWRITE && rd_hit;
    pready_next = PSEL && PENABLE && !pready_reg;
    prdata_next = (pready_next && !PWRITE) ? rd_val : 32'h00000000;
    perr_next   = pready_next && !rd_hit;
    en_next     = en_reg;
    clr_next    = 1'b0;
    alm1_next   = alm1_reg;
    alm2_next   = alm2_reg;
    inh_next    = inh_reg;
    tripl_next  = tripl_reg;
    dly_next    = dly_reg;
    pick_next   = pick_reg;
    sf_next     = sf_reg;
    kmax_next   = kmax_reg;
    kmin_next   = kmin_reg;
    nomc_next   = nomc_reg;
    tmin_next   = tmin_reg;
    tmax_next   = tmax_reg;
    if (wr_go) begin
      unique case (PADDR)
        `TOF_OFS_CTRL: begin
          en_next  = PWDATA[3:0];
          clr_next = PWDATA[`TOF_CTRL_CLR];
        end
        `TOF_OFS_ALM1:  alm1_next  = PWDATA[11:0];
        `TOF_OFS_ALM2:  alm2_next  = PWDATA[11:0];
        `TOF_OFS_INH:   inh_next   = PWDATA[11:0];
        `TOF_OFS_TRIPL: tripl_next = PWDATA[11:0];
        `TOF_OFS_DLY:   dly_next   = PWDATA[19:0];
        `TOF_OFS_PICK:  pick_next  = PWDATA[15:0];
        `TOF_OFS_SF:    sf_next    = PWDATA[8:0];
        `TOF_OFS_KMAX:  kmax_next  = PWDATA[8:0];
        `TOF_OFS_KMIN:  kmin_next  = PWDATA[8:0];
        `TOF_OFS_TEMPS: begin
          tmin_next = PWDATA[7:0];
          tmax_next = PWDATA[15:8];
        end
        `TOF_OFS_NOMC:  nomc_next  = PWDATA[8:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pready_reg <= 1'b0;
      prdata_reg <= '0;
      perr_reg   <= 1'b0;
      en_reg     <= '0;
      clr_reg    <= 1'b0;
      alm1_reg   <= `TOF_RST_ALM1;
      alm2_reg   <= `TOF_RST_ALM2;
      inh_reg    <= `TOF_RST_INH;
      tripl_reg  <= `TOF_RST_TRIPL;
      dly_reg    <= '0;
      pick_reg   <= `TOF_RST_PICK;
      sf_reg     <= `TOF_FACTOR_ONE;
      kmax_reg   <= `TOF_FACTOR_ONE;
      kmin_reg   <= `TOF_FACTOR_ONE;
      nomc_reg   <= `TOF_FACTOR_ONE;
      tmin_reg   <= `TOF_RST_TMIN;
      tmax_reg   <= `TOF_RST_TMAX;
    end else begin
      pready_reg <= pready_next;
      prdata_reg <= prdata_next;
      perr_reg   <= perr_next;
      en_reg     <= en_next;
      clr_reg    <= clr_next;
      alm1_reg   <= alm1_next;
      alm2_reg   <= alm2_next;
      inh_reg    <= inh_next;
      tripl_reg  <= tripl_next;
      dly_reg    <= dly_next;
      pick_reg   <= pick_next;
      sf_reg     <= sf_next;
      kmax_reg   <= kmax_next;
      kmin_reg   <= kmin_next;
      nomc_reg   <= nomc_next;
      tmin_reg   <= tmin_next;
      tmax_reg   <= tmax_next;
    end
  end

  // ----------------------------------------
  // pick-up, blocking and trip delay
  // ----------------------------------------
  tof_fsm_t    st_reg, st_next;
  logic [19:0] dly_cnt_reg, dly_cnt_next;
  logic        pickup;
  logic        start_reg, start_next, blocked_reg, blocked_next, trip_reg, trip_next;

  always_comb begin
    pickup       = en_reg[3] && (theta_reg >= tripl_reg);
    st_next      = st_reg;
    dly_cnt_next = dly_cnt_reg;
    if (eval_reg) begin
      unique case (st_reg)
        TOF_IDLE: begin
          dly_cnt_next = '0;
          if (pickup) begin
            st_next = blk_s_reg ? TOF_BLOCKED : TOF_TIMING;
          end
        end
        TOF_TIMING: begin
          if (!pickup || blk_s_reg) begin
            st_next = TOF_IDLE;
          end else if (dly_cnt_reg >= dly_reg) begin
            st_next = TOF_TRIPPED;
          end else begin
            dly_cnt_next = dly_cnt_reg + 20'h00001;
          end
        end
        TOF_TRIPPED: begin
          if (!pickup || blk_s_reg) begin
            st_next = TOF_IDLE;
          end
        end
        TOF_BLOCKED: begin
          if (!pickup) begin
            st_next = TOF_IDLE;
          end
        end
      endcase
    end
    start_next   = (st_next == TOF_TIMING);
    blocked_next = (st_next == TOF_BLOCKED);
    trip_next    = (st_next == TOF_TRIPPED);
  end
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_reg      <= TOF_IDLE;
      dly_cnt_reg <= '0;
      start_reg   <= 1'b0;
      blocked_reg <= 1'b0;
      trip_reg    <= 1'b0;
    end else begin
      st_reg      <= st_next;
      dly_cnt_reg <= dly_cnt_next;
      start_reg   <= start_next;
      blocked_reg <= blocked_next;
      trip_reg    <= trip_next;
    end
  end

  // ----------------------------------------
  // indications and setting checks
  // ----------------------------------------
  logic       a1_reg, a1_next, a2_reg, a2_next, inhb_reg, inhb_next;
  logic       trip_exp_next, sf_f_next, amb_f_next, nomc_f_next, incons_next;
  logic [8:0] sf_used_next, k_used_next, nomc_used_next;
  tof_cond_t  cond_next;
  tof_therm_t therm_next;

  always_comb begin
    a1_next        = a1_reg;
    a2_next        = a2_reg;
    inhb_next      = inhb_reg;
    trip_exp_next  = trip_exp_reg;
    therm_next     = therm_reg;
    sf_f_next      = sf_f_reg;
    amb_f_next     = amb_f_reg;
    nomc_f_next    = nomc_f_reg;
    incons_next    = incons_reg;
    sf_used_next   = sf_used_reg;
    k_used_next    = k_used_reg;
    nomc_used_next = nomc_used_reg;
    if (eval_reg) begin
      a1_next       = en_reg[0] && (theta_reg >= alm1_reg);
      a2_next       = en_reg[1] && (theta_reg >= alm2_reg);
      inhb_next     = en_reg[2] && (theta_reg >= inh_reg);
      trip_exp_next = est_reg >= tripl_reg;
      if (imax_reg < `TOF_I_LIGHT) begin
        therm_next = TH_LIGHT;
      end else if (imax_reg > `TOF_I_HIGH) begin
        therm_next = TH_HIGH;
      end else if (imax_reg > pick_reg) begin
        therm_next = TH_OVERLOAD;
      end else begin
        therm_next = TH_NORMAL;
      end
      sf_f_next      = (sf_reg == '0) || (sf_reg > `TOF_FACTOR_MAX);
      amb_f_next     = (kmax_reg == '0) || (kmax_reg > `TOF_FACTOR_MAX)
                    || (kmin_reg == '0) || (kmin_reg > `TOF_FACTOR_MAX);
      nomc_f_next    = (nomc_reg == '0) || (nomc_reg > `TOF_FACTOR_MAX);
      incons_next    = $signed(tmin_reg) >= $signed(tmax_reg);
      sf_used_next   = sf_f_next ? `TOF_FACTOR_ONE : sf_reg;
      k_used_next    = amb_f_next ? `TOF_FACTOR_ONE : kmax_reg;
      nomc_used_next = nomc_f_next ? `TOF_FACTOR_ONE : nomc_reg;
    end
    if (st_next == TOF_BLOCKED) begin
      cond_next = COND_BLOCKED;
    end else if (st_next == TOF_TRIPPED) begin
      cond_next = COND_TRIP;
    end else if (inhb_next) begin
      cond_next = COND_INHIBIT;
    end else if (a2_next) begin
      cond_next = COND_ALARM2;
    end else if (a1_next) begin
      cond_next = COND_ALARM1;
    end else begin
      cond_next = COND_NORMAL;
    end
  end
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      a1_reg        <= 1'b0;
      a2_reg        <= 1'b0;
      inhb_reg      <= 1'b0;
      trip_exp_reg  <= 1'b0;
      therm_reg     <= TH_LIGHT;
      sf_f_reg      <= 1'b0;
      amb_f_reg     <= 1'b0;
      nomc_f_reg    <= 1'b0;
      incons_reg    <= 1'b0;
      sf_used_reg   <= `TOF_FACTOR_ONE;
      k_used_reg    <= `TOF_FACTOR_ONE;
      nomc_used_reg <= `TOF_FACTOR_ONE;
      cond_reg      <= COND_NORMAL;
    end else begin
      a1_reg        <= a1_next;
      a2_reg        <= a2_next;
      inhb_reg      <= inhb_next;
      trip_exp_reg  <= trip_exp_next;
      therm_reg     <= therm_next;
      sf_f_reg      <= sf_f_next;
      amb_f_reg     <= amb_f_next;
      nomc_f_reg    <= nomc_f_next;
      incons_reg    <= incons_next;
      sf_used_reg   <= sf_used_next;
      k_used_reg    <= k_used_next;
      nomc_used_reg <= nomc_used_next;
      cond_reg      <= cond_next;
    end
  end

  // ----------------------------------------
  // counters and outputs
  // ----------------------------------------
  assign cb.clr    = clr_reg;
  assign cb.inc[0] = a1_next && !a1_reg;
  assign cb.inc[1] = a2_next && !a2_reg;
  assign cb.inc[2] = inhb_next && !inhb_reg;
  assign cb.inc[3] = (st_next == TOF_TRIPPED) && (st_reg != TOF_TRIPPED);
  assign cb.inc[4] = (st_next == TOF_BLOCKED) && (st_reg != TOF_BLOCKED);

  tof_cnt_bank u_cnt (
    .clk  (CLK),
    .rstn (RSTN),
    .cb   (cb.bank)
  );

  assign PRDATA        = prdata_reg;
  assign PREADY        = pready_reg;
  assign PSLVERR       = perr_reg;
  assign START         = start_reg;
  assign BLOCKED       = blocked_reg;
  assign TRIP          = trip_reg;
  assign ALARM1        = a1_reg;
  assign ALARM2        = a2_reg;
  assign INHIBIT       = inhb_reg;
  assign TRIP_EXPECTED = trip_exp_reg;
  assign CONDITION     = cond_reg;
  assign THERM_STATE   = therm_reg;
  assign SF_FAULT      = sf_f_reg;
  assign AMB_FAULT     = amb_f_reg;
  assign NOMC_FAULT    = nomc_f_reg;
  assign AMBK_INCONS   = incons_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence s_pick_free;
    eval_reg && st_reg == TOF_IDLE && pickup && !blk_s_reg;
  endsequence
  sequence s_pick_blocked;
    eval_reg && st_reg == TOF_IDLE && pickup && blk_s_reg;
  endsequence

  a_block_hold: assert property (!cyc_en_reg |=> $stable(blk_s_reg))
    else $error("blocking sample moved inside a cycle");
  a_start_go: assert property (s_pick_free |=> START && !BLOCKED)
    else $error("unblocked pick-up gave no start");
  a_block_gate: assert property (s_pick_blocked |=> BLOCKED ##1 !START)
    else $error("blocked pick-up went on processing");
  a_block_drop: assert property (eval_reg && START && blk_s_reg |=> !START && !TRIP)
    else $error("start survived blocking");
  a_normal_quiet: assert property (CONDITION == COND_NORMAL
      |-> !(ALARM1 || ALARM2 || INHIBIT || TRIP || BLOCKED))
    else $error("output active in normal condition");
  a_light_state: assert property (eval_reg && imax_reg < `TOF_I_LIGHT
      |=> THERM_STATE == TH_LIGHT)
    else $error("light load not reported");
  a_high_state: assert property (eval_reg && imax_reg > `TOF_I_HIGH
      |=> THERM_STATE == TH_HIGH)
    else $error("high overload not reported");
  a_sf_fallback: assert property (eval_reg && sf_reg == '0
      |=> SF_FAULT && sf_used_reg == `TOF_FACTOR_ONE)
    else $error("service factor fault not handled");
  a_trip_delay: assert property ($rose(TRIP) |-> $past(dly_cnt_reg) >= dly_reg)
    else $error("trip before its delay");
  a_trip_count: assert property (cb.inc[3] && !clr_reg && cb.cnt[3] != `TOF_CNT_MAX
      |=> cb.cnt[3] == $past(cb.cnt[3]) + 16'h0001)
    else $error("trip not counted");
endmodule

// ---- bench/tof_far_model.sv ----
// far-side model of blocking matrix and phase current sources
`timescale 1ns/1ps
module tof_far_model (
  output logic        blk,
  output logic [15:0] ia,
  output logic [15:0] ib,
  output logic [15:0] ic,
  output logic [11:0] th,
  output logic [11:0] est
);
  initial begin
    {blk, ia, ib, ic, th, est} = '0;
  end
  // blocking driven in the same step as the phase currents and thermal levels
  task set_in(input logic b, input logic [15:0] a, input logic [15:0] bb,
              input logic [15:0] c, input logic [11:0] t);
    blk <= b;
    {ia, ib, ic} <= {a, bb, c};
    {th, est} <= {t, t};
  endtask
endmodule

// ---- bench/tb_top.sv ----
// self-checking bench of the thermal overload status logic
`timescale 1ns/1ps
`include "tof_params.svh"
module tb_top;
  import tof_pkg::*;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, err, blk, start, blocked, al1, al2, inh, trip, texp;
  logic sff, ambf, nomf, incf;
  logic [15:0] ia, ib, ic;
  logic [11:0] th, est;
  tof_cond_t cond;
  tof_therm_t therm;
  int miscompares = 0, samples_checked = 0, n;
  logic [15:0] cur [4][3] = '{'{16'h5, 16'h2, 16'h3}, '{16'h64, 16'h1F4, 16'h14},
                              '{16'h0, 16'h0, 16'h5DC}, '{16'h9C4, 16'h0, 16'h0}};
  logic [15:0] imax [4] = '{16'h5, 16'h1F4, 16'h5DC, 16'h9C4};
  always #5 clk = ~clk;
  tof_far_model tof_far_model_inst (.blk(blk), .ia(ia), .ib(ib), .ic(ic),
    .th(th), .est(est));
  tof_status #(.CYCLE_CLKS(8)) tof_status_inst (.CLK(clk), .RSTN(rstn), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .BLOCK_IN(blk), .PHASE_A_CURRENT(ia),
    .PHASE_B_CURRENT(ib), .PHASE_C_CURRENT(ic), .THETA(th), .THETA_EST(est),
    .START(start), .BLOCKED(blocked), .ALARM1(al1), .ALARM2(al2), .INHIBIT(inh),
    .TRIP(trip), .TRIP_EXPECTED(texp), .CONDITION(cond), .THERM_STATE(therm),
    .SF_FAULT(sff), .AMB_FAULT(ambf), .NOMC_FAULT(nomf), .AMBK_INCONS(incf));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 50);
    q = prdata; err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clk);
    chk("apb_answer", 1, k < 50);
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(nm, e, q);
  endtask
  task wait_ev(input int e);
    repeat (e * 8 + 4) @(posedge clk);
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100us;
    miscompares++;
    test_done;
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    rdc("alm1_rst", `TOF_OFS_ALM1, `TOF_RST_ALM1);
    rdc("inh_rst", `TOF_OFS_INH, `TOF_RST_INH);
    apb(0, 8'hFC, 32'h0);
    chk("unmapped_err", 1, err);
    chk("unmapped_data", 0, q);
    $display("test reset_regs done");
    for (int i = 0; i < 4; i++) begin
      tof_far_model_inst.set_in(0, cur[i][0], cur[i][1], cur[i][2], 0);
      wait_ev(2);
      chk("therm", i, therm);
      rdc("imax", `TOF_OFS_IMAX, imax[i]);
    end
    $display("test therm_state done");
    apb(1, `TOF_OFS_DLY, 32'h2);
    apb(1, `TOF_OFS_CTRL, 32'h8);
    tof_far_model_inst.set_in(0, 0, 16'h5DC, 0, 12'h3E8);
    for (n = 0; n < 40 && start !== 1'b1; n++) @(posedge clk);
    chk("start", 1, start);
    chk("trip_early", 0, trip);
    for (n = 0; n < 40 && trip !== 1'b1; n++) @(posedge clk);
    chk("trip_gap", 24, n);
    chk("cond_trip", COND_TRIP, cond);
    chk("texp_hi", 1, texp);
    rdc("trip_cnt", `TOF_OFS_CNTB, 32'h0001_0000);
    $display("test trip done");
    tof_far_model_inst.set_in(1, 0, 16'h5DC, 0, 12'h3E8);
    for (n = 0; n < 60 && blocked !== 1'b1; n++) @(posedge clk);
    chk("blk_outs", 3'b010, {start, blocked, trip});
    chk("cond_blk", COND_BLOCKED, cond);
    rdc("blk_cnt", `TOF_OFS_CNTC, 32'h1);
    tof_far_model_inst.set_in(0, 0, 0, 0, 0);
    wait_ev(3);
    chk("normal_outs", 0, {start, blocked, al1, al2, inh, trip});
    chk("cond_norm", COND_NORMAL, cond);
    apb(1, `TOF_OFS_CTRL, 32'h100);
    rdc("cnt_clr", `TOF_OFS_CNTB, 32'h0);
    $display("test blocking done");
    apb(1, `TOF_OFS_CTRL, 32'h7);
    tof_far_model_inst.set_in(0, 0, 0, 0, 12'h320);
    wait_ev(2);
    chk("alarm_outs", 4'hE, {al1, al2, inh, trip});
    chk("cond_inh", COND_INHIBIT, cond);
    chk("texp_low", 0, texp);
    rdc("alarm_cnt", `TOF_OFS_CNTA, 32'h0001_0001);
    rdc("inh_cnt", `TOF_OFS_CNTB, 32'h0000_0001);
    $display("test alarms done");
    apb(1, `TOF_OFS_SF, 0);
    apb(1, `TOF_OFS_KMAX, 0);
    apb(1, `TOF_OFS_NOMC, 0);
    apb(1, `TOF_OFS_TEMPS, 0);
    wait_ev(2);
    chk("faults", 4'hF, {sff, ambf, nomf, incf});
    rdc("used", `TOF_OFS_USED, 32'h0190_C864);
    apb(1, `TOF_OFS_SF, 32'h78);
    apb(1, `TOF_OFS_KMAX, 32'h64);
    apb(1, `TOF_OFS_NOMC, 32'h64);
    apb(1, `TOF_OFS_TEMPS, 32'h2D00);
    wait_ev(2);
    chk("faults_gone", 0, {sff, ambf, nomf, incf});
    rdc("used_ok", `TOF_OFS_USED, 32'h0190_C878);
    $display("test setting_faults done");
    test_done;
  end
endmodule
